// *** logic/pcspi_consts.svh ***
`ifndef PCSPI_CONSTS_SVH
`define PCSPI_CONSTS_SVH

// Register indices; byte address is four times the index
`define PCSPI_IDX_CTRL       5'h00
`define PCSPI_IDX_STAT       5'h01
`define PCSPI_IDX_DYN        5'h11

// Control register field positions
`define PCSPI_CTRL_RESET_BIT 15
`define PCSPI_CTRL_PDOWN_BIT 11
`define PCSPI_CTRL_ISO_BIT   10
`define PCSPI_CTRL_ANRS_BIT  9

// Status register field positions
`define PCSPI_STAT_LOWPWR_BIT 0
`define PCSPI_STAT_ISO_BIT    1
`define PCSPI_STAT_SGMII_BIT  2
`define PCSPI_STAT_MGMT_BIT   3

// Reset values
`define PCSPI_ISO_RESET_VAL   1'h1
`define PCSPI_SGMII_RESET_VAL 1'h0
`define PCSPI_GMII_IDLE_DATA  8'h00

// AXI4-Lite responses
`define PCSPI_RESP_OKAY      2'h0
`define PCSPI_RESP_SLVERR    2'h2

// Shared GMII clock rate for core and MAC, in MHz
`define PCSPI_GMII_CLK_MHZ   125

`endif

// *** logic/pcspi_pkg.sv ***
`include "pcspi_consts.svh"

package pcspi_pkg;

    typedef enum logic [0:0] {
        PCSPI_PWR_ACTIVE = 1'b0,
        PCSPI_PWR_LOW    = 1'b1
    } pcspi_pwr_e;

    typedef struct packed {
        logic [7:0] data;
        logic       dv;
        logic       er;
    } pcspi_gmii_rx_s;

    typedef struct packed {
        logic [7:0] data;
        logic       en;
        logic       er;
    } pcspi_gmii_tx_s;

    typedef struct packed {
        pcspi_gmii_rx_s rx;
        pcspi_gmii_tx_s tx;
        logic           rx_oe_n;
    } pcspi_gate_s;

    typedef struct packed {
        pcspi_pwr_e  pwr;
        logic        iso;
        logic        sgmii;
        logic        aw_held;
        logic [7:0]  awaddr;
        logic        w_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        soft_rst;
        logic        an_restart;
    } pcspi_main_s;

endpackage

// *** logic/pcspi_gmii_gate.sv ***
`timescale 1ns/1ps
`include "pcspi_consts.svh"

module pcspi_gmii_gate (
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic                     ce,
    input  wire logic                     isolate,
    input  wire pcspi_pkg::pcspi_gmii_rx_s rx_in,
    input  wire pcspi_pkg::pcspi_gmii_tx_s tx_in,
    output pcspi_pkg::pcspi_gmii_rx_s      rx_out,
    output pcspi_pkg::pcspi_gmii_tx_s      tx_out,
    output logic                           rx_oe_n
);
    import pcspi_pkg::*;

    localparam pcspi_gmii_rx_s RX_IDLE = '{data: `PCSPI_GMII_IDLE_DATA, dv: 1'b0, er: 1'b0};
    localparam pcspi_gmii_tx_s TX_IDLE = '{data: `PCSPI_GMII_IDLE_DATA, en: 1'b0, er: 1'b0};
    localparam pcspi_gate_s    GATE_RESET = '{rx: RX_IDLE, tx: TX_IDLE, rx_oe_n: 1'b1};

    pcspi_gate_s gate_reg;
    pcspi_gate_s gate_next;

    always_comb begin
        gate_next = gate_reg;
        if (ce) begin
            if (isolate) begin
                gate_next.rx      = RX_IDLE;
                gate_next.tx      = TX_IDLE;
                gate_next.rx_oe_n = 1'b1;
            end else begin
                gate_next.rx      = rx_in;
                gate_next.tx      = tx_in;
                gate_next.rx_oe_n = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gate_reg <= GATE_RESET;
        end else begin
            gate_reg <= gate_next;
        end
    end

    assign rx_out  = gate_reg.rx;
    assign tx_out  = gate_reg.tx;
    assign rx_oe_n = gate_reg.rx_oe_n;

endmodule

// *** logic/pcspi_power_isolate.sv ***
// Contract
// - Whole GMII on one shared clock
// - Registers reachable by the managing party
// - Control write enters low power
// - Low power left only by reset
// - Vector power-down bit enters low power
// - Vector low power left by reset port
// - No low power in ten-bit builds
// - Power up isolated (vector builds follow cfg_isolate), receive pins released
// - Standard switch: immediate, no restart
`timescale 1ns/1ps
`include "pcspi_consts.svh"

module pcspi_power_isolate #(
    parameter bit HAS_MGMT = 1'b1,
    parameter bit IS_TBI   = 1'b0
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      ce,
    input  wire logic [7:0]                s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [7:0]                s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      cfg_power_down,
    input  wire logic                      cfg_isolate,
    input  wire pcspi_pkg::pcspi_gmii_rx_s core_rx,
    output pcspi_pkg::pcspi_gmii_tx_s      core_tx,
    input  wire pcspi_pkg::pcspi_gmii_tx_s mac_tx,
    output pcspi_pkg::pcspi_gmii_rx_s      mac_rx,
    output logic                           mac_rx_oe_n,
    output logic                           xcvr_power_down,
    output logic                           soft_reset_pulse,
    output logic                           an_restart_pulse,
    output logic                           standard_sgmii
);
    import pcspi_pkg::*;

    localparam pcspi_main_s MAIN_RESET = '{
        pwr: PCSPI_PWR_ACTIVE, iso: `PCSPI_ISO_RESET_VAL, sgmii: `PCSPI_SGMII_RESET_VAL,
        bresp: `PCSPI_RESP_OKAY, rresp: `PCSPI_RESP_OKAY, default: '0};

    pcspi_main_s main_reg;
    pcspi_main_s main_next;
    logic        isolated;
    logic        do_wr;
    logic        ctrl_wr;
    logic        dyn_wr;
    logic [4:0]  wr_idx;

    // Decodes a read; the top bit carries the error flag
    function automatic logic [32:0] read_word(input logic [7:0] addr, input pcspi_main_s s,
                                              input logic iso_now);
        logic [31:0] w;
        logic        err;
        w   = '0;
        err = 1'b0;
        if (addr[1:0] != 2'h0) begin
            err = 1'b1;
        end else begin
            case (addr[6:2])
                `PCSPI_IDX_CTRL: begin
                    w[`PCSPI_CTRL_PDOWN_BIT] = (s.pwr == PCSPI_PWR_LOW);
                    w[`PCSPI_CTRL_ISO_BIT]   = s.iso;
                end
                `PCSPI_IDX_STAT: begin
                    w[`PCSPI_STAT_LOWPWR_BIT] = (s.pwr == PCSPI_PWR_LOW);
                    w[`PCSPI_STAT_ISO_BIT]    = iso_now;
                    w[`PCSPI_STAT_SGMII_BIT]  = s.sgmii;
                    w[`PCSPI_STAT_MGMT_BIT]   = HAS_MGMT;
                end
                `PCSPI_IDX_DYN: begin
                    w[0] = s.sgmii;
                end
                default: begin
                    err = 1'b1;
                end
            endcase
            if (addr[7]) begin
                err = 1'b1;
            end
        end
        return {err, w};
    endfunction

    assign isolated = HAS_MGMT ? main_reg.iso : cfg_isolate;

    assign s_axi_awready = ce && !main_reg.aw_held && !main_reg.bvalid;
    assign s_axi_wready  = ce && !main_reg.w_held && !main_reg.bvalid;
    assign s_axi_arready = ce && !main_reg.rvalid;

    assign do_wr   = main_reg.aw_held && main_reg.w_held && !main_reg.bvalid;
    assign wr_idx  = main_reg.awaddr[6:2];
    assign ctrl_wr = do_wr && HAS_MGMT && (wr_idx == `PCSPI_IDX_CTRL) && main_reg.wstrb[1];
    assign dyn_wr  = do_wr && (wr_idx == `PCSPI_IDX_DYN) && main_reg.wstrb[0];

    always_comb begin
        logic [32:0] rd;
        rd = '0;
        main_next = main_reg;
        main_next.soft_rst   = 1'b0;
        main_next.an_restart = 1'b0;
        if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                main_next.aw_held = 1'b1;
                main_next.awaddr  = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                main_next.w_held = 1'b1;
                main_next.wdata  = s_axi_wdata;
                main_next.wstrb  = s_axi_wstrb;
            end
            if (do_wr) begin
                main_next.aw_held = 1'b0;
                main_next.w_held  = 1'b0;
                main_next.bvalid  = 1'b1;
                rd = read_word(main_reg.awaddr, main_reg, isolated);
                main_next.bresp = rd[32] ? `PCSPI_RESP_SLVERR : `PCSPI_RESP_OKAY;
            end
            if (ctrl_wr) begin
                if (main_reg.wdata[`PCSPI_CTRL_RESET_BIT]) begin
                    main_next.soft_rst = 1'b1;
                    main_next.pwr      = PCSPI_PWR_ACTIVE;
                    main_next.iso      = `PCSPI_ISO_RESET_VAL;
                end else begin
                    main_next.iso        = main_reg.wdata[`PCSPI_CTRL_ISO_BIT];
                    main_next.an_restart = main_reg.wdata[`PCSPI_CTRL_ANRS_BIT];
                    if (main_reg.wdata[`PCSPI_CTRL_PDOWN_BIT] && !IS_TBI) begin
                        main_next.pwr = PCSPI_PWR_LOW;
                    end
                end
            end
            if (dyn_wr) begin
                main_next.sgmii = main_reg.wdata[0];
            end
            if (!HAS_MGMT && !IS_TBI && cfg_power_down) begin
                main_next.pwr = PCSPI_PWR_LOW;
            end
            if (main_reg.bvalid && s_axi_bready) begin
                main_next.bvalid = 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rd = read_word(s_axi_araddr, main_reg, isolated);
                main_next.rvalid = 1'b1;
                main_next.rdata  = rd[31:0];
                main_next.rresp  = rd[32] ? `PCSPI_RESP_SLVERR : `PCSPI_RESP_OKAY;
            end
            if (main_reg.rvalid && s_axi_rready) begin
                main_next.rvalid = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            main_reg <= MAIN_RESET;
        end else begin
            main_reg <= main_next;
        end
    end

    assign s_axi_bvalid     = main_reg.bvalid;
    assign s_axi_bresp      = main_reg.bresp;
    assign s_axi_rvalid     = main_reg.rvalid;
    assign s_axi_rdata      = main_reg.rdata;
    assign s_axi_rresp      = main_reg.rresp;
    assign xcvr_power_down  = (main_reg.pwr == PCSPI_PWR_LOW);
    assign soft_reset_pulse = main_reg.soft_rst;
    assign an_restart_pulse = main_reg.an_restart;
    assign standard_sgmii   = main_reg.sgmii;

    // One clock for both GMII paths
    pcspi_gmii_gate u_gate (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .isolate (isolated),
        .rx_in   (core_rx),
        .tx_in   (mac_tx),
        .rx_out  (mac_rx),
        .tx_out  (core_tx),
        .rx_oe_n (mac_rx_oe_n)
    );

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_pdown_write;
        ctrl_wr && ce && !main_reg.wdata[`PCSPI_CTRL_RESET_BIT]
            && main_reg.wdata[`PCSPI_CTRL_PDOWN_BIT];
    endsequence

    sequence s_soft_reset_write;
        ctrl_wr && ce && main_reg.wdata[`PCSPI_CTRL_RESET_BIT];
    endsequence

    property p_pdown_enter;
        s_pdown_write |=> (xcvr_power_down == !IS_TBI);
    endproperty
    a_pdown_enter: assert property (p_pdown_enter) else $error("power-down write ignored");

    property p_low_sticky;
        xcvr_power_down && !(ctrl_wr && ce && main_reg.wdata[`PCSPI_CTRL_RESET_BIT])
            |=> xcvr_power_down;
    endproperty
    a_low_sticky: assert property (p_low_sticky) else $error("low power left without reset");

    property p_soft_exit;
        s_soft_reset_write |=> !xcvr_power_down && soft_reset_pulse && main_reg.iso ##1
            !soft_reset_pulse;
    endproperty
    a_soft_exit: assert property (p_soft_exit) else $error("software reset misbehaved");

    property p_vector_pdown;
        !HAS_MGMT && ce && cfg_power_down |=> (xcvr_power_down == !IS_TBI);
    endproperty
    a_vector_pdown: assert property (p_vector_pdown) else $error("vector power-down ignored");

    property p_vector_sticky;
        !HAS_MGMT && xcvr_power_down |=> xcvr_power_down;
    endproperty
    a_vector_sticky: assert property (p_vector_sticky) else $error("vector low power left");

    property p_tbi_never_low;
        IS_TBI |-> !xcvr_power_down;
    endproperty
    a_tbi_never_low: assert property (p_tbi_never_low) else $error("ten-bit build in low power");

    property p_isolate_idle;
        isolated && ce |=> mac_rx_oe_n && !mac_rx.dv && !mac_rx.er && !core_tx.en && !core_tx.er;
    endproperty
    a_isolate_idle: assert property (p_isolate_idle) else $error("GMII active while isolated");

    property p_dyn_switch;
        dyn_wr && ce |=> (standard_sgmii == $past(main_reg.wdata[0])) && !an_restart_pulse;
    endproperty
    a_dyn_switch: assert property (p_dyn_switch) else $error("standard switch wrong");

    // Answer must rise, then stand one more cycle if rready is low
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid and (!s_axi_rready |=> s_axi_rvalid);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer dropped");

    property p_write_answer;
        do_wr && ce |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("write not answered");

endmodule

// *** verification/pcspi_mac_model.sv ***
`timescale 1ns/1ps

module pcspi_mac_model (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 send,
    output pcspi_pkg::pcspi_gmii_tx_s mac_tx
);
    import pcspi_pkg::*;
    logic [7:0] cnt_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
    // Byte changes every cycle so a stale copy shows
    assign mac_tx = send ? pcspi_gmii_tx_s'{data: cnt_reg, en: 1'b1, er: 1'b0} : '0;
endmodule

// *** verification/test_pcspi_power_isolate.sv ***
`timescale 1ns/1ps
`include "pcspi_consts.svh"

module test_pcspi_power_isolate;
    import pcspi_pkg::*;
    logic           aclk, aresetn, ce, cfg_pd, cfg_iso, send;
    logic [7:0]     awaddr, araddr;
    logic           awvalid, wvalid, bready, arvalid, rready;
    logic           awready, wready, bvalid, arready, rvalid;
    logic [31:0]    wdata, rdata, d;
    logic [3:0]     wstrb;
    logic [1:0]     bresp, rresp, r;
    pcspi_gmii_rx_s core_rx, mac_rx;
    pcspi_gmii_tx_s core_tx, mac_tx, p;
    logic           oe_n, pd, srst, anrs, sgmii;
    logic           v_oe, v_pd, t_pd;
    pcspi_gmii_rx_s v_rx;
    int             fail_count, num_checks, n_srst, n_anrs;

    pcspi_power_isolate dut (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .ce              (ce),
        .s_axi_awaddr    (awaddr),
        .s_axi_awvalid   (awvalid),
        .s_axi_awready   (awready),
        .s_axi_wdata     (wdata),
        .s_axi_wstrb     (wstrb),
        .s_axi_wvalid    (wvalid),
        .s_axi_wready    (wready),
        .s_axi_bresp     (bresp),
        .s_axi_bvalid    (bvalid),
        .s_axi_bready    (bready),
        .s_axi_araddr    (araddr),
        .s_axi_arvalid   (arvalid),
        .s_axi_arready   (arready),
        .s_axi_rdata     (rdata),
        .s_axi_rresp     (rresp),
        .s_axi_rvalid    (rvalid),
        .s_axi_rready    (rready),
        .cfg_power_down  (cfg_pd),
        .cfg_isolate     (cfg_iso),
        .core_rx         (core_rx),
        .core_tx         (core_tx),
        .mac_tx          (mac_tx),
        .mac_rx          (mac_rx),
        .mac_rx_oe_n     (oe_n),
        .xcvr_power_down (pd),
        .soft_reset_pulse(srst),
        .an_restart_pulse(anrs),
        .standard_sgmii  (sgmii)
    );

    // Vector build, isolate held high at power-on
    pcspi_power_isolate #(
        .HAS_MGMT(1'b0),
        .IS_TBI  (1'b0)
    ) dut_vec (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .ce              (ce),
        .s_axi_awaddr    (awaddr),
        .s_axi_awvalid   (awvalid),
        .s_axi_awready   (),
        .s_axi_wdata     (wdata),
        .s_axi_wstrb     (wstrb),
        .s_axi_wvalid    (wvalid),
        .s_axi_wready    (),
        .s_axi_bresp     (),
        .s_axi_bvalid    (),
        .s_axi_bready    (bready),
        .s_axi_araddr    (araddr),
        .s_axi_arvalid   (arvalid),
        .s_axi_arready   (),
        .s_axi_rdata     (),
        .s_axi_rresp     (),
        .s_axi_rvalid    (),
        .s_axi_rready    (rready),
        .cfg_power_down  (cfg_pd),
        .cfg_isolate     (cfg_iso),
        .core_rx         (core_rx),
        .core_tx         (),
        .mac_tx          (mac_tx),
        .mac_rx          (v_rx),
        .mac_rx_oe_n     (v_oe),
        .xcvr_power_down (v_pd),
        .soft_reset_pulse(),
        .an_restart_pulse(),
        .standard_sgmii  ()
    );

    // Ten-bit build follows the same bus in lockstep
    pcspi_power_isolate #(
        .HAS_MGMT(1'b1),
        .IS_TBI  (1'b1)
    ) dut_tbi (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .ce              (ce),
        .s_axi_awaddr    (awaddr),
        .s_axi_awvalid   (awvalid),
        .s_axi_awready   (),
        .s_axi_wdata     (wdata),
        .s_axi_wstrb     (wstrb),
        .s_axi_wvalid    (wvalid),
        .s_axi_wready    (),
        .s_axi_bresp     (),
        .s_axi_bvalid    (),
        .s_axi_bready    (bready),
        .s_axi_araddr    (araddr),
        .s_axi_arvalid   (arvalid),
        .s_axi_arready   (),
        .s_axi_rdata     (),
        .s_axi_rresp     (),
        .s_axi_rvalid    (),
        .s_axi_rready    (rready),
        .cfg_power_down  (cfg_pd),
        .cfg_isolate     (cfg_iso),
        .core_rx         (core_rx),
        .core_tx         (),
        .mac_tx          (mac_tx),
        .mac_rx          (),
        .mac_rx_oe_n     (),
        .xcvr_power_down (t_pd),
        .soft_reset_pulse(),
        .an_restart_pulse(),
        .standard_sgmii  ()
    );

    pcspi_mac_model mac (
        .aclk   (aclk),
        .aresetn(aresetn),
        .send   (send),
        .mac_tx (mac_tx)
    );

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Pulses last one cycle, so count them mid-cycle
    always @(negedge aclk) begin
        n_srst += int'(srst === 1'b1);
        n_anrs += int'(anrs === 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ha, hw, da, dw, hb;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        da = 1'b0;
        dw = 1'b0;
        while (!(da && dw)) begin
            @(negedge aclk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            @(posedge aclk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            da |= ha;
            dw |= hw;
        end
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            hb = bvalid;
            r = bresp;
            @(posedge aclk);
        end while (hb !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        logic h;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge aclk);
            h = arready;
            @(posedge aclk);
        end while (h !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            h = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
        end while (h !== 1'b1);
        rready <= 1'b0;
    endtask

    task automatic t_reset;
        @(negedge aclk);
        check(oe_n, 1'b1, "receive pins driven after reset");
        check(mac_rx, '0, "receive not idle while isolated");
        check(core_tx, '0, "transmit passed while isolated");
        @(posedge aclk);
        rd(8'h00);
        check(d, 32'h400, "control reset value");
        rd(8'h04);
        check(d, 32'ha, "status reset value");
        $display("test reset done");
    endtask

    task automatic t_iso;
        wr(8'h00, 32'h0);
        check(r, `PCSPI_RESP_OKAY, "control write refused");
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        check(mac_rx, core_rx, "receive not passed");
        check(oe_n, 1'b0, "receive pins not driven");
        p = mac_tx;
        @(posedge aclk);
        @(negedge aclk);
        check(core_tx, p, "transmit not one edge behind");
        @(posedge aclk);
        $display("test isolate done");
    endtask

    task automatic t_pwr;
        wr(8'h00, 32'h800);
        check(pd, 1'b1, "power down not entered");
        check(t_pd, 1'b0, "ten-bit build in low power");
        wr(8'h00, 32'h0);
        check(pd, 1'b1, "low power left without reset");
        rd(8'h04);
        check(d, 32'h9, "status in low power");
        wr(8'h00, 32'h8000);
        check(n_srst, 1, "soft reset pulse count");
        check(pd, 1'b0, "soft reset kept low power");
        rd(8'h00);
        check(d, 32'h400, "control after soft reset");
        wr(8'h00, 32'h800);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check(pd, 1'b0, "port reset kept low power");
        @(posedge aclk);
        $display("test power done");
    endtask

    task automatic t_vec;
        check(v_oe, 1'b1, "vector isolate ignored");
        cfg_iso <= 1'b0;
        cfg_pd  <= 1'b1;
        repeat (2) @(posedge aclk);
        cfg_pd <= 1'b0;
        @(negedge aclk);
        check(v_oe, 1'b0, "vector isolate not released");
        check(v_rx, core_rx, "vector receive not passed");
        check(v_pd, 1'b1, "vector power-down ignored");
        @(posedge aclk);
        wr(8'h00, 32'h8000);
        check(v_pd, 1'b1, "vector low power left by write");
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        check(v_pd, 1'b0, "port reset kept vector low power");
        @(posedge aclk);
        $display("test vector done");
    endtask

    task automatic t_dyn;
        wr(8'h44, 32'h1);
        check(sgmii, 1'b1, "standard not switched");
        check(n_anrs, 0, "switch restarted negotiation");
        rd(8'h44);
        check(d, 32'h1, "switch readback");
        wr(8'h00, 32'h200);
        check(n_anrs, 1, "restart pulse missing");
        wr(8'h08, 32'hffff);
        check(r, `PCSPI_RESP_SLVERR, "unmapped write");
        rd(8'h08);
        check(d, 32'h0, "unmapped read data");
        check(r, `PCSPI_RESP_SLVERR, "unmapped read");
        wr(8'h04, 32'hffff);
        check(r, `PCSPI_RESP_OKAY, "status write response");
        rd(8'h04);
        check(d, 32'hc, "status read only");
        $display("test switch done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run is under a hundred cycles
    initial begin
        repeat (4000) @(posedge aclk);
        fail_count++;
        results();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {cfg_pd, cfg_iso, awaddr, araddr, wdata} = '0;
        cfg_iso = 1'b1;
        {ce, send} = 2'b11;
        wstrb = 4'hf;
        core_rx = '{data: 8'h5a, dv: 1'b1, er: 1'b1};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_iso();
        t_pwr();
        t_vec();
        t_dyn();
        results();
    end
endmodule
